//--- core/ftsr_pkg.sv
package ftsr_pkg;

  // ==========================================================================
  // Register addresses (holding register numbers on the register port)
  localparam logic [15:0] ADDR_TEST_MODE_READBACK = 16'h9C51;
  localparam logic [15:0] ADDR_TEST_CONC_READBACK = 16'h9C52;
  localparam logic [15:0] ADDR_TEST_MODE_CONTROL  = 16'h9C70;
  localparam logic [15:0] ADDR_TEST_CONC_SETTING  = 16'h9C71;
  localparam logic [15:0] ADDR_DEVICE_STATUS_WORD = 16'h9E44;

  // ==========================================================================
  // Field positions in the status word
  localparam int BIT_SENSOR_FAULT = 10;
  localparam int BIT_HEATER_BREAK = 11;
  localparam int BIT_LOW_FLOW_2   = 12;
  localparam int BIT_LOW_FLOW_1   = 13;
  localparam int BIT_TEST_MODE    = 2;

  // ==========================================================================
  // Codes, limits and reset values
  localparam logic [15:0] TEST_MODE_ON     = 16'h0001;
  localparam logic [15:0] TEST_MODE_OFF    = 16'h0000;
  localparam logic [15:0] CONC_MIN         = 16'h0001;
  localparam logic [15:0] CONC_MAX         = 16'h0064;
  localparam logic [6:0]  CONC_RESET       = 7'h64;
  localparam logic [15:0] UNMAPPED_READ    = 16'h0000;

  // ==========================================================================
  // Timing
  localparam longint CLOCK_HZ          = 20000000;
  localparam longint TEST_TIMEOUT_MIN  = 10;
  localparam longint TEST_TIMEOUT_CYC  = TEST_TIMEOUT_MIN * 64'd60 * CLOCK_HZ;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic        low_flow_1;
    logic        low_flow_2;
    logic        heater_break;
    logic        sensor_fault;
  } ftsr_fault_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [15:0] wdata;
  } ftsr_req_t;

endpackage

//--- core/ftsr_regs.sv
`timescale 1ns/1ps
// Function
// - The status word at 40516 carries status byte one high and status byte two low.
// - Trouble flags follow their fault condition and clear by themselves, no acknowledge.
// - Trouble flags live in bits 2 to 5 of the upper byte, 1 meaning fault.
// - Upper bit 5 shows the mild low-flow level.
// - Upper bit 4 shows the severe low-flow level that also raises the low-flow alarm.
// - Upper bit 3 shows a broken heated decomposition element wire when one is fitted.
// - Upper bit 2 shows a very low sensor zero level or a broken combustible sensor wire.
// - A write of 0x0001 to 40048 enters test mode and 0x0000 leaves it.
// - A write to 40049 sets the test concentration, 1 to 100 percent.
// - Test mode ends by itself ten minutes after it was entered, from any source.
// - Each press of the local test button toggles test mode.
// - Lower bit 2 of the status word reads 1 while test mode is on.
// - 40017 reads back test mode state and 40018 the test concentration.
// - The gas alarm contact outputs are driven active while test mode is on.
module ftsr_regs #(
  parameter longint TIMEOUT_CYC = ftsr_pkg::TEST_TIMEOUT_CYC
) (
  input  wire logic                 clock,
  input  wire logic                 sys_rst,
  input  wire ftsr_pkg::ftsr_req_t  req,
  output logic [15:0]               rdata,
  output logic                      rvalid,
  input  wire ftsr_pkg::ftsr_fault_t fault_pin,
  input  wire logic                 heater_fitted,
  input  wire logic                 test_button,
  output logic                      test_mode,
  output logic [6:0]                test_conc,
  output logic                      alarm_contact_1,
  output logic                      alarm_contact_2,
  output logic                      low_flow_alarm
);

  // Timer is 40 bits wide: ten minutes at 20 MHz does not fit in 32
  if (TIMEOUT_CYC < 1 || TIMEOUT_CYC > 64'h000000FFFFFFFFFF) begin : g_bad_timeout
    $error("TIMEOUT_CYC out of range");
  end

  // ==========================================================================
  // State
  typedef struct packed {
    ftsr_pkg::ftsr_fault_t f_s1;
    ftsr_pkg::ftsr_fault_t f_s2;
    logic                  btn_s1;
    logic                  btn_s2;
    logic                  btn_prev;
    logic                  fit_s1;
    logic                  fit_s2;
    logic                  test;
    logic [39:0]           tmr;
    logic [6:0]            conc;
    logic [15:0]           rdata;
    logic                  rvalid;
  } ftsr_state_t;

  ftsr_state_t st_r;
  ftsr_state_t st_nxt;
  logic [15:0] status_word;

  // Status word built straight from synchronised levels: no latching, so
  // each flag drops on its own as soon as the fault goes away.
  always_comb begin
    status_word = 16'h0000;
    status_word[ftsr_pkg::BIT_LOW_FLOW_1]   = st_r.f_s2.low_flow_1;
    status_word[ftsr_pkg::BIT_LOW_FLOW_2]   = st_r.f_s2.low_flow_2;
    status_word[ftsr_pkg::BIT_HEATER_BREAK] = st_r.f_s2.heater_break & st_r.fit_s2;
    status_word[ftsr_pkg::BIT_SENSOR_FAULT] = st_r.f_s2.sensor_fault;
    status_word[ftsr_pkg::BIT_TEST_MODE]    = st_r.test;
  end

  // ==========================================================================
  // Next state
  always_comb begin
    st_nxt        = st_r;
    st_nxt.f_s1   = fault_pin;
    st_nxt.f_s2   = st_r.f_s1;
    st_nxt.btn_s1 = test_button;
    st_nxt.btn_s2 = st_r.btn_s1;
    st_nxt.btn_prev = st_r.btn_s2;
    st_nxt.fit_s1 = heater_fitted;
    st_nxt.fit_s2 = st_r.fit_s1;
    st_nxt.rvalid = 1'b0;

    // Timeout runs only while on; any entry restarts it from zero
    if (st_r.test) begin
      st_nxt.tmr = st_r.tmr + 40'h0000000001;
    end
    if (st_r.test && st_r.tmr >= 40'(TIMEOUT_CYC - 1)) begin
      st_nxt.test = 1'b0;
    end

    // Button press wins over a master write in the same cycle
    if (req.wr && req.addr == ftsr_pkg::ADDR_TEST_MODE_CONTROL) begin
      if (req.wdata == ftsr_pkg::TEST_MODE_ON) begin
        if (!st_r.test) begin
          st_nxt.tmr = 40'h0000000000;
        end
        st_nxt.test = 1'b1;
      end else if (req.wdata == ftsr_pkg::TEST_MODE_OFF) begin
        st_nxt.test = 1'b0;
      end
      // Other codes leave the mode untouched
    end
    if (st_r.btn_s2 && !st_r.btn_prev) begin
      st_nxt.test = !st_r.test;
      st_nxt.tmr  = 40'h0000000000;
    end

    if (req.wr && req.addr == ftsr_pkg::ADDR_TEST_CONC_SETTING &&
        req.wdata >= ftsr_pkg::CONC_MIN && req.wdata <= ftsr_pkg::CONC_MAX) begin
      st_nxt.conc = req.wdata[6:0];
    end

    if (req.rd) begin
      st_nxt.rvalid = 1'b1;
      case (req.addr)
        ftsr_pkg::ADDR_DEVICE_STATUS_WORD: st_nxt.rdata = status_word;
        ftsr_pkg::ADDR_TEST_MODE_READBACK: st_nxt.rdata = {15'h0000, st_r.test};
        ftsr_pkg::ADDR_TEST_CONC_READBACK: st_nxt.rdata = {9'h000, st_r.conc};
        default:                           st_nxt.rdata = ftsr_pkg::UNMAPPED_READ;
      endcase
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      st_r      <= '0;
      st_r.conc <= ftsr_pkg::CONC_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================================
  // Outputs
  assign rdata           = st_r.rdata;
  assign rvalid          = st_r.rvalid;
  assign test_mode       = st_r.test;
  assign test_conc       = st_r.conc;
  // Contacts driven active during test; the master must clear interlocks first
  assign alarm_contact_1 = st_r.test;
  assign alarm_contact_2 = st_r.test;
  assign low_flow_alarm  = st_r.f_s2.low_flow_2;

endmodule

//--- sim/ftsr_props.sv
`timescale 1ns/1ps
// ======
// Checks
module ftsr_props (
  input wire logic                clock,
  input wire logic                sys_rst,
  input wire ftsr_pkg::ftsr_req_t req,
  input wire logic [15:0]         rdata,
  input wire logic                rvalid,
  input wire logic                test_button,
  input wire logic                test_mode,
  input wire logic [6:0]          test_conc,
  input wire logic                alarm_contact_1,
  input wire logic                alarm_contact_2
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  wire logic       ctl  = req.wr && req.addr == ftsr_pkg::ADDR_TEST_MODE_CONTROL;
  wire logic       won  = ctl && req.wdata == ftsr_pkg::TEST_MODE_ON;
  wire logic       cset = req.wr && req.addr == ftsr_pkg::ADDR_TEST_CONC_SETTING;
  wire logic       inr  = req.wdata >= ftsr_pkg::CONC_MIN && req.wdata <= ftsr_pkg::CONC_MAX;
  wire logic [6:0] wlow = req.wdata[6:0];
  // A press lands three cycles late, so mode writes are judged only with the button quiet
  sequence quiet; !test_button [*4]; endsequence
  chk_mode_on: assert property (
    quiet ##0 (won && !test_mode) |=> test_mode) else $error("test mode not entered");
  chk_mode_off: assert property (
    quiet ##0 (ctl && req.wdata == ftsr_pkg::TEST_MODE_OFF) |=> !test_mode) else $error("not left");
  chk_bad_code: assert property (
    quiet ##0 (ctl && req.wdata > 16'h0001 && !test_mode) |=> !test_mode) else $error("bad code");
  chk_conc_take: assert property (
    cset && inr |=> test_conc == $past(wlow)) else $error("conc not stored");
  chk_conc_keep: assert property (
    cset && !inr |=> $stable(test_conc)) else $error("conc changed");
  chk_rd_answer: assert property (
    req.rd |=> rvalid) else $error("read not answered");
  chk_status_bit: assert property (
    req.rd && req.addr == ftsr_pkg::ADDR_DEVICE_STATUS_WORD |=> rdata[2] == $past(test_mode))
    else $error("status test bit");
  chk_contact_follow: assert property (
    alarm_contact_1 == test_mode && alarm_contact_2 == test_mode) else $error("contacts");
endmodule
bind ftsr_regs ftsr_props ftsr_props_inst (.clock(clock), .sys_rst(sys_rst), .req(req),
  .rdata(rdata), .rvalid(rvalid), .test_button(test_button), .test_mode(test_mode),
  .test_conc(test_conc), .alarm_contact_1(alarm_contact_1), .alarm_contact_2(alarm_contact_2));

//--- sim/ftsr_master.sv
`timescale 1ns/1ps
// ============
// Polling master
module ftsr_master (
  input wire logic            clock,
  input wire logic [15:0]     rdata,
  input wire logic            rvalid,
  output ftsr_pkg::ftsr_req_t req
);
  initial req = '0;
  task automatic access(input logic w, input logic [15:0] a, d, output logic [15:0] q);
    @(posedge clock) req <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge clock) req <= '0;
    q = 16'h0000;
    if (w) return;
    repeat (3) begin
      #1;
      if (rvalid === 1'b1) begin
        q = rdata;
        return;
      end
      @(posedge clock);
    end
    testbench.errors++;
    testbench.finish_test();
  endtask
endmodule

//--- sim/testbench.sv
`timescale 1ns/1ps
// =====
// Bench
module testbench;
  logic                  clock = 0, sys_rst = 1, heater_fitted = 0, test_button = 0;
  logic                  rvalid, test_mode, ac1, ac2, low_flow_alarm;
  logic [15:0]           rdata, q;
  logic [6:0]            test_conc;
  ftsr_pkg::ftsr_fault_t fault_pin = '0;
  ftsr_pkg::ftsr_req_t   req;
  int                    errors = 0, cmp_count = 0;
  // Write address, write data, read address, expected read data
  logic [63:0]           rows [10] = '{64'h9C70_0001_9C51_0001, 64'h9C71_0019_9C52_0019,
    64'h9C71_0065_9C52_0019, 64'h9C71_0000_9C52_0019, 64'h9C71_0064_9C52_0064,
    64'h9C71_0001_9C52_0001, 64'h9C70_0002_9E44_0004, 64'h9C70_0000_9C51_0000,
    64'h9C70_0100_9E44_0000, 64'h1234_0001_1234_0000};
  always #25 clock = ~clock;
  ftsr_master ftsr_master_inst (.clock(clock), .rdata(rdata), .rvalid(rvalid), .req(req));
  ftsr_regs #(.TIMEOUT_CYC(400)) ftsr_regs_inst (.clock(clock), .sys_rst(sys_rst), .req(req),
    .rdata(rdata), .rvalid(rvalid), .fault_pin(fault_pin), .heater_fitted(heater_fitted),
    .test_button(test_button), .test_mode(test_mode), .test_conc(test_conc),
    .alarm_contact_1(ac1), .alarm_contact_2(ac2), .low_flow_alarm(low_flow_alarm));
  task automatic chk(input logic [15:0] seen, exp, input string name);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic finish_test();
    if (errors == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clock);
    chk({9'h000, test_conc}, 16'h0064, "conc at reset");
    sys_rst <= 0;
    foreach (rows[i]) begin
      ftsr_master_inst.access(1, rows[i][63:48], rows[i][47:32], q);
      ftsr_master_inst.access(0, rows[i][31:16], 16'h0000, q);
      chk(q, rows[i][15:0], "row read");
    end
    heater_fitted <= 1;
    for (int i = 0; i < 4; i++) begin
      @(posedge clock) fault_pin <= 4'h1 << i;
      repeat (4) @(posedge clock);
      ftsr_master_inst.access(0, ftsr_pkg::ADDR_DEVICE_STATUS_WORD, 16'h0000, q);
      chk(q, 16'h0400 << i, "fault bit");
      chk({15'h0000, low_flow_alarm}, 16'(i == 2), "low flow alarm");
    end
    @(posedge clock) fault_pin <= 4'h2;
    heater_fitted <= 0;
    repeat (4) @(posedge clock);
    ftsr_master_inst.access(0, ftsr_pkg::ADDR_DEVICE_STATUS_WORD, 16'h0000, q);
    chk(q, 16'h0000, "cleared and gated");
    for (int k = 0; k < 3; k++) begin
      @(posedge clock) test_button <= 1;
      @(posedge clock) test_button <= 0;
      repeat (5) @(posedge clock);
      #1 chk({13'h0000, ac1, ac2, test_mode}, k[0] ? 16'h0000 : 16'h0007, "press");
    end
    repeat (385) @(posedge clock);
    #1 chk({15'h0000, test_mode}, 16'h0001, "before timeout");
    repeat (20) @(posedge clock);
    #1 chk({15'h0000, test_mode}, 16'h0000, "after timeout");
    finish_test();
  end
endmodule
